// [src/bpwm_map.svh]
// Constants of the buffered PWM timer
`ifndef BPWM_MAP_SVH
`define BPWM_MAP_SVH
`define BPWM_MOD_RESET    16'hFFFF
`define BPWM_CNT_RESET    16'h0000
`define BPWM_PS_RESET     3'h0
`define BPWM_MODE_UNBUF   2'h1
`define BPWM_MODE_BUF     2'h2
`define BPWM_EL_CLEAR     2'h2
`define BPWM_EL_SET       2'h3
`endif

// [src/bpwm_pkg.sv]
// Types of the buffered PWM timer
package bpwm_pkg;
    typedef logic [15:0] bpwm_word_t;
endpackage : bpwm_pkg

// [src/bpwm_timer.sv]
// Six-channel 16-bit timer with unbuffered and buffered PWM
`include "bpwm_map.svh"
module bpwm_timer
    import bpwm_pkg::*;
#(
    parameter int NCH = 6
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    // Low-power modes
    input  wire logic             wait_mode,
    input  wire logic             stop_mode,
    // Counter control
    input  wire logic             counter_halt,
    input  wire logic             counter_reset,
    input  wire logic [2:0]       prescale_sel,
    input  wire logic             overflow_irq_enable,
    input  wire logic             status_read,
    input  wire logic             overflow_flag_wr0,
    input  wire bpwm_word_t       period_modulo_value,
    input  wire logic             modulo_wr,
    // Channel configuration
    input  wire logic [NCH*2-1:0] channel_mode_field,
    input  wire logic [NCH*2-1:0] channel_edge_level_field,
    input  wire logic [NCH-1:0]   toggle_at_overflow,
    input  wire logic [NCH-1:0]   full_duty_force,
    input  wire logic [NCH-1:0]   channel_irq_enable,
    input  wire logic [NCH-1:0]   chan_flag_wr0,
    // Channel compare values
    input  wire bpwm_word_t       cmp_wdata,
    input  wire logic [NCH-1:0]   cmp_wr,
    // Outputs
    output logic [NCH-1:0]        chan_pin,
    output logic [NCH-1:0]        chan_pin_oe,
    output logic                  overflow_flag,
    output logic [NCH-1:0]        channel_event_flag,
    output logic [NCH/2-1:0]      pair_active_odd,
    output bpwm_word_t            counter_value,
    output logic                  timer_irq,
    output logic                  wake_request
);
    ////////////////////////////////////////////////////////////////////////////
    bpwm_word_t  cnt_q, mod_q;
    bpwm_word_t  cmp_q [NCH];
    logic [5:0]  pre_q;
    logic        tof_q, tof_armed_q;
    logic [NCH-1:0] chf_q, out_q, chf_armed_q;
    logic [NCH/2-1:0] act_q, pend_q;
    wire run      = clk_en && !stop_mode;
    // Registers are not reachable in wait mode
    wire reg_acc  = run && !wait_mode;
    wire tick_pre = (prescale_sel == 3'h7) ? 1'b0 :
                    ((pre_q & ((6'h01 << prescale_sel) - 6'h01)) == 6'h00);
    wire tick     = !counter_halt && tick_pre;
    wire ovf      = tick && (cnt_q == mod_q);
    wire trst     = reg_acc && counter_reset;

    ////////////////////////////////////////////////////////////////////////////
    // counter and prescaler reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= `BPWM_CNT_RESET;
            pre_q <= 6'h00;
        end else if (trst) begin
            cnt_q <= `BPWM_CNT_RESET;
            pre_q <= 6'h00;
        end else if (run && !counter_halt) begin
            pre_q <= pre_q + 6'h01;
            if (tick) begin
                cnt_q <= ovf ? `BPWM_CNT_RESET : cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mod_q <= `BPWM_MOD_RESET;
        end else if (reg_acc && modulo_wr) begin
            mod_q <= period_modulo_value;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tof_q       <= 1'b0;
            tof_armed_q <= 1'b0;
        end else if (run) begin
            if (ovf) begin
                tof_q       <= 1'b1;
                tof_armed_q <= 1'b0;
            end else if (reg_acc && overflow_flag_wr0 && tof_armed_q) begin
                tof_q       <= 1'b0;
                tof_armed_q <= 1'b0;
            end else if (reg_acc && status_read && tof_q) begin
                tof_armed_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            localparam int EV = g & ~1;
            localparam int PR = g / 2;
            wire pair_buf = channel_mode_field[EV*2+1];
            // odd channel of a linked pair is idle
            wire odd_idle = (g % 2 == 1) && pair_buf;
            wire cmp_mode = (g % 2 == 0 && pair_buf) ||
                            (channel_mode_field[g*2+1 -: 2] == `BPWM_MODE_UNBUF);
            // source is the active channel of a pair
            wire [15:0] src = (g % 2 == 0 && pair_buf && act_q[PR]) ?
                              cmp_q[g+1] : cmp_q[g];
            wire match = tick && (cnt_q == src) && cmp_mode && !odd_idle;
            wire [1:0] el = channel_edge_level_field[g*2+1 -: 2];

            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    cmp_q[g] <= 16'h0000;
                end else if (reg_acc && cmp_wr[g]) begin
                    cmp_q[g] <= cmp_wdata;
                end
            end

            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    out_q[g] <= 1'b0;
                end else if (run && cmp_mode && !odd_idle) begin
                    if (full_duty_force[g] && toggle_at_overflow[g]) begin
                        out_q[g] <= (el == `BPWM_EL_CLEAR);
                    end else if (match && el == `BPWM_EL_CLEAR) begin
                        out_q[g] <= 1'b0;
                    end else if (match && el == `BPWM_EL_SET) begin
                        out_q[g] <= 1'b1;
                    end else if (match && el == 2'h1) begin
                        out_q[g] <= ~out_q[g];
                    end else if (ovf && toggle_at_overflow[g]) begin
                        out_q[g] <= ~out_q[g];
                    end
                end
            end

            // channel flag, set wins over clear
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    chf_q[g]       <= 1'b0;
                    chf_armed_q[g] <= 1'b0;
                end else if (run) begin
                    if (match) begin
                        chf_q[g]       <= 1'b1;
                        chf_armed_q[g] <= 1'b0;
                    end else if (reg_acc && chan_flag_wr0[g] && chf_armed_q[g]) begin
                        chf_q[g]       <= 1'b0;
                        chf_armed_q[g] <= 1'b0;
                    end else if (reg_acc && status_read && chf_q[g]) begin
                        chf_armed_q[g] <= 1'b1;
                    end
                end
            end

            assign chan_pin_oe[g] = cmp_mode && !odd_idle;
            assign chan_pin[g]    = out_q[g];
        end

        for (g = 0; g < NCH / 2; g++) begin : g_pair
            wire linked = channel_mode_field[g*4+1];
            always_ff @(posedge clk) begin
                if (!rst_n || !linked) begin
                    act_q[g]  <= 1'b0;
                    pend_q[g] <= 1'b0;
                end else if (run) begin
                    if (ovf) begin
                        act_q[g]  <= pend_q[g];
                    end
                    if (reg_acc && cmp_wr[g*2+1]) begin
                        pend_q[g] <= 1'b1;
                    end else if (reg_acc && cmp_wr[g*2]) begin
                        pend_q[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    assign overflow_flag      = tof_q;
    assign channel_event_flag = chf_q;
    assign pair_active_odd    = act_q;
    assign counter_value      = cnt_q;
    assign timer_irq    = (tof_q && overflow_irq_enable) || |(chf_q & channel_irq_enable);
    assign wake_request = wait_mode && timer_irq;

    ////////////////////////////////////////////////////////////////////////////
    overflow_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ovf && run && !trst) |=> (cnt_q == 16'h0000) && tof_q)
        else $error("counter did not restart at modulo");
    stop_freeze_a: assert property (@(posedge clk) disable iff (!rst_n)
        stop_mode |=> ($stable(cnt_q) && $stable(out_q) && $stable(tof_q)))
        else $error("state changed in stop mode");
    reset_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
        trst |=> (cnt_q == 16'h0000) && (pre_q == 6'h00))
        else $error("counter reset did not clear");
    flag_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
        (tof_q && !tof_armed_q) |=> tof_q)
        else $error("overflow flag cleared without read");
    ovf_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
        (tof_q && overflow_irq_enable) |-> timer_irq)
        else $error("overflow interrupt missing");
    odd_release_a: assert property (@(posedge clk) disable iff (!rst_n)
        channel_mode_field[1] |-> !chan_pin_oe[1])
        else $error("odd pin still driven while linked");
    switch_boundary_a: assert property (@(posedge clk) disable iff (!rst_n)
        (channel_mode_field[1] && !(ovf && run)) |=> $stable(act_q[0]) || !channel_mode_field[1])
        else $error("active channel changed mid-period");
    last_written_a: assert property (@(posedge clk) disable iff (!rst_n)
        (channel_mode_field[1] && ovf && run && channel_mode_field[1]) |=> act_q[0] == $past(pend_q[0]) || !channel_mode_field[1])
        else $error("wrong source after overflow");

    ////////////////////////////////////////////////////////////////////////////
    // Channel 0 stands for every pair, since all share one generate body
    sequence full_pulse_s;
        run && g_ch[0].cmp_mode && full_duty_force[0] && toggle_at_overflow[0] &&
            (channel_edge_level_field[1:0] == `BPWM_EL_CLEAR);
    endsequence
    sequence zero_hold_s;
        run && g_ch[0].cmp_mode && !toggle_at_overflow[0] && !full_duty_force[0] &&
            !chan_pin[0] && (channel_edge_level_field[1:0] == `BPWM_EL_CLEAR);
    endsequence
    sequence odd_write_s;
        reg_acc && channel_mode_field[1] && cmp_wr[1];
    endsequence

    wait_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        (run && wait_mode && tick && !ovf) |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("counter stalled in wait mode");
    wait_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        (run && wait_mode && modulo_wr) |=> $stable(mod_q))
        else $error("register written in wait mode");
    wake_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wait_mode && timer_irq) |-> wake_request)
        else $error("enabled interrupt did not wake");
    clken_freeze_a: assert property (@(posedge clk) disable iff (!rst_n)
        !clk_en |=> ($stable(cnt_q) && $stable(pre_q) && $stable(tof_q) && $stable(act_q)))
        else $error("state changed with clock enable low");
    irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!overflow_irq_enable && !(|(chf_q & channel_irq_enable))) |-> !timer_irq)
        else $error("interrupt raised while disabled");
    chan_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        (run && g_ch[0].match) |=> channel_event_flag[0])
        else $error("channel flag not set on compare");
    buf_priority_a: assert property (@(posedge clk) disable iff (!rst_n)
        channel_mode_field[1] |-> chan_pin_oe[0])
        else $error("even pin not driven while linked");
    full_duty_a: assert property (@(posedge clk) disable iff (!rst_n)
        full_pulse_s |=> chan_pin[0])
        else $error("full duty output dropped");
    zero_duty_a: assert property (@(posedge clk) disable iff (!rst_n)
        zero_hold_s |=> !chan_pin[0])
        else $error("zero duty output rose");
    first_link_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(channel_mode_field[1]) |-> !act_q[0])
        else $error("odd channel active on first link");
    odd_pending_a: assert property (@(posedge clk) disable iff (!rst_n)
        odd_write_s |=> pend_q[0] || !channel_mode_field[1])
        else $error("odd write not recorded as pending");
    reset_scope_a: assert property (@(posedge clk) disable iff (!rst_n)
        (trst && !modulo_wr) |=> $stable(mod_q))
        else $error("counter reset changed modulo");
    odd_silent_a: assert property (@(posedge clk) disable iff (!rst_n)
        (run && channel_mode_field[1] && !channel_event_flag[1]) |=> !channel_event_flag[1])
        else $error("odd channel flagged while linked");
endmodule : bpwm_timer

// [bench/bpwm_load_model.sv]
// Load model on the timer channel pins, with pull-downs and a high-time counter
module bpwm_load_model
    import bpwm_pkg::*;
(
    // Clock and measurement control
    input  wire logic       clk,
    input  wire logic       meas_clr,
    // Timer pins
    input  wire logic [5:0] chan_pin,
    input  wire logic [5:0] chan_pin_oe,
    // Observed levels
    output logic [5:0]      pin_level,
    output bpwm_word_t      high_cnt
);
    timeunit 1ns;
    timeprecision 100ps;
    // A released pin falls to the pull-down, so a stale level cannot pass
    assign pin_level = chan_pin & chan_pin_oe;
    always @(posedge clk) begin
        high_cnt <= meas_clr ? 16'h0000 : high_cnt + {15'h0000, pin_level[0]};
    end
endmodule : bpwm_load_model

// [bench/bpwm_timer_test.sv]
// Self-checking bench of the buffered PWM timer
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module bpwm_timer_test
    import bpwm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, wait_mode = 1'b0, stop_mode = 1'b0;
    logic        counter_halt = 1'b1, counter_reset = 1'b0, overflow_irq_enable = 1'b0;
    logic        status_read = 1'b0, overflow_flag_wr0 = 1'b0, modulo_wr = 1'b0, meas_clr = 1'b0;
    logic        overflow_flag, timer_irq, wake_request;
    logic [2:0]  prescale_sel = 3'h0, pair_active_odd;
    logic [11:0] channel_mode_field = 12'h000, channel_edge_level_field = 12'h000;
    logic [5:0]  toggle_at_overflow = 6'h00, full_duty_force = 6'h00, channel_irq_enable = 6'h00;
    logic [5:0]  chan_flag_wr0 = 6'h00, cmp_wr = 6'h00, chan_pin, chan_pin_oe, channel_event_flag;
    logic [5:0]  pin_level;
    bpwm_word_t  period_modulo_value = 16'h0003, cmp_wdata = 16'h0000, counter_value, high_cnt, v;
    int          bad_count = 0, checks_done = 0, cycles = 0;

    bpwm_timer uut (
        .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .wait_mode(wait_mode), .stop_mode(stop_mode),
        .counter_halt(counter_halt), .counter_reset(counter_reset), .prescale_sel(prescale_sel),
        .overflow_irq_enable(overflow_irq_enable), .status_read(status_read),
        .overflow_flag_wr0(overflow_flag_wr0), .period_modulo_value(period_modulo_value),
        .modulo_wr(modulo_wr), .channel_mode_field(channel_mode_field),
        .channel_edge_level_field(channel_edge_level_field), .toggle_at_overflow(toggle_at_overflow),
        .full_duty_force(full_duty_force), .channel_irq_enable(channel_irq_enable),
        .chan_flag_wr0(chan_flag_wr0), .cmp_wdata(cmp_wdata), .cmp_wr(cmp_wr), .chan_pin(chan_pin),
        .chan_pin_oe(chan_pin_oe), .overflow_flag(overflow_flag),
        .channel_event_flag(channel_event_flag), .pair_active_odd(pair_active_odd),
        .counter_value(counter_value), .timer_irq(timer_irq), .wake_request(wake_request));
    bpwm_load_model load (.clk(clk), .meas_clr(meas_clr), .chan_pin(chan_pin),
        .chan_pin_oe(chan_pin_oe), .pin_level(pin_level), .high_cnt(high_cnt));

    always #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    // Whole run needs well under 1000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic wr_cmp(input int ch, input bpwm_word_t d);
        cmp_wdata = d;
        cmp_wr = 6'h01 << ch;
        tick(1);
        cmp_wr = 6'h00;
    endtask : wr_cmp
    // High cycles of pin 0 over 16 cycles, four periods of modulo 3
    task automatic duty(input bpwm_word_t e);
        meas_clr = 1'b1;
        tick(1);
        meas_clr = 1'b0;
        tick(16);
        `CHK(high_cnt, e)
    endtask : duty
    task automatic init_pwm(input bpwm_word_t w, input logic [11:0] mode);
        counter_halt = 1'b1;
        counter_reset = 1'b1;
        modulo_wr = 1'b1;
        tick(1);
        counter_reset = 1'b0;
        modulo_wr = 1'b0;
        wr_cmp(0, w);
        channel_mode_field = mode;
        // toggle at overflow, clear on compare
        toggle_at_overflow = 6'h01;
        channel_edge_level_field = 12'h002;
        counter_halt = 1'b0;
        tick(12);
    endtask : init_pwm
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_unbuf();
        init_pwm(16'h0000, 12'h001);
        duty(16'h0004);
        channel_edge_level_field = 12'h003;
        tick(8);
        duty(16'h000C);
        channel_edge_level_field = 12'h002;
        `CHK(overflow_flag, 1'b1)
        `CHK(channel_event_flag[0], 1'b1)
        overflow_irq_enable = 1'b1;
        wait_mode = 1'b1;
        tick(1);
        `CHK(wake_request, 1'b1)
        v = counter_value;
        tick(1);
        `CHK(counter_value, (v + 16'h0001) & 16'h0003)
        wait_mode = 1'b0;
        $display("unbuffered test done");
    endtask : t_unbuf
    task automatic t_limits();
        toggle_at_overflow = 6'h00;
        tick(8);
        duty(16'h0000);
        toggle_at_overflow = 6'h01;
        full_duty_force = 6'h01;
        tick(4);
        duty(16'h0010);
        full_duty_force = 6'h00;
        stop_mode = 1'b1;
        v = counter_value;
        tick(10);
        `CHK(counter_value, v)
        stop_mode = 1'b0;
        tick(1);
        `CHK(counter_value, (v + 16'h0001) & 16'h0003)
        $display("duty limit and stop test done");
    endtask : t_limits
    task automatic t_clear();
        counter_halt = 1'b1;
        status_read = 1'b1;
        tick(1);
        status_read = 1'b0;
        overflow_flag_wr0 = 1'b1;
        counter_reset = 1'b1;
        tick(1);
        overflow_flag_wr0 = 1'b0;
        counter_reset = 1'b0;
        tick(1);
        `CHK(overflow_flag, 1'b0)
        `CHK(counter_value, 16'h0000)
        `CHK(timer_irq, 1'b0)
        channel_irq_enable = 6'h01;
        tick(1);
        `CHK(timer_irq, 1'b1)
        channel_irq_enable = 6'h00;
        overflow_irq_enable = 1'b0;
        $display("flag clear test done");
    endtask : t_clear
    task automatic t_gating();
        prescale_sel = 3'h1;
        counter_halt = 1'b1;
        counter_reset = 1'b1;
        tick(1);
        counter_reset = 1'b0;
        counter_halt = 1'b0;
        tick(4);
        `CHK(counter_value, 16'h0002)
        clk_en = 1'b0;
        v = counter_value;
        tick(5);
        `CHK(counter_value, v)
        clk_en = 1'b1;
        prescale_sel = 3'h0;
        $display("prescale and clock enable test done");
    endtask : t_gating
    // only the inactive channel of the pair is written
    task automatic t_buffered();
        init_pwm(16'h0000, 12'h002);
        `CHK(chan_pin_oe[1:0], 2'h1)
        `CHK(pair_active_odd[0], 1'b0)
        duty(16'h0004);
        channel_edge_level_field = 12'h00E;
        counter_halt = 1'b1;
        wr_cmp(1, 16'h0002);
        tick(4);
        `CHK(pair_active_odd[0], 1'b0)
        counter_halt = 1'b0;
        tick(8);
        `CHK(pair_active_odd[0], 1'b1)
        duty(16'h000C);
        channel_mode_field = 12'h003;
        counter_halt = 1'b1;
        wr_cmp(0, 16'h0001);
        counter_halt = 1'b0;
        tick(8);
        `CHK(chan_pin_oe[1:0], 2'h1)
        duty(16'h0008);
        $display("buffered test done");
    endtask : t_buffered
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(2);
        rst_n = 1'b1;
        t_unbuf();
        t_limits();
        t_clear();
        t_gating();
        t_buffered();
        print_verdict();
    end
endmodule : bpwm_timer_test
